/* File: flash_spm_pkg.sv */
// Purpose: shared constants and types of the flash self-program controller
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: offsets are byte addresses on the register bus
package flash_spm_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFS = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_RSVD_LSB = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // command codes in the lower six control bits
   // ---------------------------------------------------------------
   localparam logic [5:0] CMD_LOAD = 6'h01;
   localparam logic [5:0] CMD_ERASE = 6'h03;
   localparam logic [5:0] CMD_WRITE = 6'h05;
   localparam logic [5:0] CMD_FUSE = 6'h09;
   localparam logic [5:0] CMD_CLEAR = 6'h11;
   localparam logic [5:0] CMD_SIG = 6'h21;
   // ---------------------------------------------------------------
   // timing, in cpu clock cycles
   // ---------------------------------------------------------------
   localparam int SPM_WINDOW_CYC = 4;
   localparam int LPM_WINDOW_CYC = 3;
   localparam int WIN_CNT_W = 3;
   // ---------------------------------------------------------------
   // fuse and lock selection by the low pointer bits
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
   localparam logic [1:0] SEL_LOCK = 2'h1;
   localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
   localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_ERASE = 2'b10,
      ST_WRITE = 2'b11
   } seq_state_t;

   typedef struct packed {
      logic sig;
      logic clear_page_buffer_cmd;
      logic fuse_lock_read_cmd;
      logic page_write_cmd;
      logic page_erase_cmd;
      logic en;
   } ctrl_t;

   typedef struct packed {
      logic spm;
      logic load_program_instruction;
      logic [15:0] ptr;
      logic [15:0] data;
   } cpu_req_t;

   typedef struct packed {
      logic [7:0] fuse_low;
      logic [7:0] lock;
      logic [7:0] fuse_ext;
      logic [7:0] fuse_high;
   } fuse_set_t;
endpackage : flash_spm_pkg

/* File: window_timer.sv */
// Purpose: command window counter, restarts on demand, saturates
// Assumes: restart is a one-cycle pulse
// Notes: count reads 0 in the cycle after a restart
`timescale 1ns/1ps
module window_timer #(
   parameter int W = 3
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic restart,
   output logic [W-1:0] count
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   initial begin
      if (W < 2) $error("window_timer: W too small");
   end

   always_comb begin
      nxt_cnt = cnt_ff;
      if (restart) begin
         nxt_cnt = '0;
      end else if (cnt_ff != {W{1'b1}}) begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_ff <= {W{1'b1}};
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign count = cnt_ff;
endmodule : window_timer

/* File: page_buffer.sv */
// Purpose: temporary page buffer storage, one write port, registered read
// Assumes: validity of each word is tracked outside
// Notes: contents are not cleared, the owner masks unloaded words
`timescale 1ns/1ps
module page_buffer #(
   parameter int AW = 6,
   parameter int DW = 16
) (
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] rd_ff;

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_ff <= mem[rd_addr];
   end

   assign rd_data = rd_ff;
endmodule : page_buffer

/* File: flash_self_program_control.sv */
// Purpose: self-program sequencer for on-chip program flash
// Assumes: cpu request, eeprom and flash signals come from clk_sys logic
// Notes: control register at offset 0x00 over axi4-lite
`timescale 1ns/1ps
module flash_self_program_control #(
   parameter int PW = 6,
   parameter logic [47:0] SIG_ROW = 48'h5a_a5_3c_c3_0f_f0 // arbitrary
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire flash_spm_pkg::cpu_req_t req,
   input wire logic eeprom_write,
   input wire flash_spm_pkg::fuse_set_t fuses,
   output logic cpu_halt,
   output logic lpm_valid,
   output logic [7:0] lpm_data,
   output logic flash_erase_req,
   output logic flash_write_req,
   output logic [14-PW:0] flash_page,
   input wire logic flash_done,
   input wire logic [PW-1:0] flash_rd_addr,
   output logic [15:0] flash_rd_data
);
   localparam int NW = 2**PW;
   localparam int CW = flash_spm_pkg::WIN_CNT_W;
   localparam logic [CW-1:0] SPM_LAST =
      CW'(flash_spm_pkg::SPM_WINDOW_CYC - 1);
   localparam logic [CW-1:0] LPM_LAST =
      CW'(flash_spm_pkg::LPM_WINDOW_CYC - 1);

   initial begin
      if (PW < 1 || PW > 14) $error("flash_self_program_control: bad PW");
   end

   // ---------------------------------------------------------------
   // register bus slave
   // ---------------------------------------------------------------
   logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
   logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid;
   logic [7:0] waddr_ff, nxt_waddr;
   logic [7:0] wbyte_ff, nxt_wbyte;
   logic wstrb0_ff, nxt_wstrb0;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic ctrl_wr;
   flash_spm_pkg::ctrl_t cmd_ff, nxt_cmd;

   assign awready = !aw_held_ff && !bvalid_ff;
   assign wready = !w_held_ff && !bvalid_ff;
   assign arready = !rvalid_ff;

   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_waddr = waddr_ff;
      nxt_wbyte = wbyte_ff;
      nxt_wstrb0 = wstrb0_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      ctrl_wr = 1'b0;
      if (awvalid && awready) begin
         nxt_aw_held = 1'b1;
         nxt_waddr = awaddr;
      end
      if (wvalid && wready) begin
         nxt_w_held = 1'b1;
         nxt_wbyte = wdata[7:0];
         nxt_wstrb0 = wstrb[0];
      end
      if (aw_held_ff && w_held_ff) begin
         nxt_aw_held = 1'b0;
         nxt_w_held = 1'b0;
         nxt_bvalid = 1'b1;
         if (waddr_ff[7:2] == flash_spm_pkg::CTRL_OFFS[7:2]) begin
            nxt_bresp = flash_spm_pkg::RESP_OKAY;
            ctrl_wr = wstrb0_ff;
         end else begin
            nxt_bresp = flash_spm_pkg::RESP_SLVERR;
         end
      end else if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         nxt_rvalid = 1'b1;
         if (araddr[7:2] == flash_spm_pkg::CTRL_OFFS[7:2]) begin
            nxt_rdata = {24'h000000, 2'b00, cmd_ff};
            nxt_rresp = flash_spm_pkg::RESP_OKAY;
         end else begin
            nxt_rdata = 32'h00000000;
            nxt_rresp = flash_spm_pkg::RESP_SLVERR;
         end
      end else if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         waddr_ff <= 8'h00;
         wbyte_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= 2'h0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         waddr_ff <= nxt_waddr;
         wbyte_ff <= nxt_wbyte;
         wstrb0_ff <= nxt_wstrb0;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   // ---------------------------------------------------------------
   // command sequencer
   // ---------------------------------------------------------------
   flash_spm_pkg::seq_state_t state_ff, nxt_state;
   logic [NW-1:0] loaded_ff, nxt_loaded;
   logic [14-PW:0] page_ff, nxt_page;
   logic erase_req_ff, nxt_erase_req, write_req_ff, nxt_write_req;
   logic lpm_valid_ff, nxt_lpm_valid;
   logic [7:0] lpm_data_ff, nxt_lpm_data;
   logic [CW-1:0] win_cnt;
   logic restart, buf_we, rd_cmd, wr_legal, rd_valid_ff;
   logic [5:0] wr_cmd;
   logic [PW-1:0] word_idx;
   logic [14-PW:0] page_idx;
   logic [15:0] buf_q;

   assign word_idx = req.ptr[PW:1];
   assign page_idx = req.ptr[15:PW+1];
   assign wr_cmd = wbyte_ff[5:0];
   assign rd_cmd = cmd_ff.sig || cmd_ff.fuse_lock_read_cmd;

   always_comb begin
      case (wr_cmd)
         flash_spm_pkg::CMD_LOAD, flash_spm_pkg::CMD_ERASE,
         flash_spm_pkg::CMD_WRITE, flash_spm_pkg::CMD_FUSE,
         flash_spm_pkg::CMD_CLEAR, flash_spm_pkg::CMD_SIG: wr_legal = 1'b1;
         default: wr_legal = 1'b0;
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cmd = cmd_ff;
      nxt_loaded = loaded_ff;
      nxt_page = page_ff;
      nxt_erase_req = 1'b0;
      nxt_write_req = 1'b0;
      nxt_lpm_valid = 1'b0;
      nxt_lpm_data = lpm_data_ff;
      restart = 1'b0;
      buf_we = 1'b0;
      case (state_ff)
         flash_spm_pkg::ST_IDLE, flash_spm_pkg::ST_ARMED: begin
            if (ctrl_wr && wr_legal) begin
               // a fresh control write re-arms, counted from next cycle
               nxt_cmd = flash_spm_pkg::ctrl_t'(wr_cmd);
               restart = 1'b1;
               nxt_state = flash_spm_pkg::ST_ARMED;
               if (wr_cmd == flash_spm_pkg::CMD_CLEAR) begin
                  nxt_loaded = '0;
               end
            end else if (state_ff == flash_spm_pkg::ST_ARMED) begin
               if (req.spm && !rd_cmd && win_cnt <= SPM_LAST) begin
                  if (cmd_ff.page_erase_cmd) begin
                     nxt_erase_req = 1'b1;
                     nxt_page = page_idx;
                     nxt_state = flash_spm_pkg::ST_ERASE;
                  end else if (cmd_ff.page_write_cmd) begin
                     nxt_write_req = 1'b1;
                     nxt_page = page_idx;
                     nxt_state = flash_spm_pkg::ST_WRITE;
                  end else begin
                     buf_we = !cmd_ff.clear_page_buffer_cmd;
                     nxt_loaded[word_idx] = loaded_ff[word_idx] ||
                        !cmd_ff.clear_page_buffer_cmd;
                     nxt_cmd = '0;
                     nxt_state = flash_spm_pkg::ST_IDLE;
                  end
               end else if (req.load_program_instruction && rd_cmd && win_cnt <= LPM_LAST) begin
                  nxt_lpm_valid = 1'b1;
                  if (cmd_ff.sig) begin
                     // unused row addresses read as erased
                     nxt_lpm_data = (req.ptr[15:0] < 16'h0006) ?
                        SIG_ROW[req.ptr[2:0]*8 +: 8] :
                        flash_spm_pkg::ERASED_BYTE;
                  end else begin
                     case (req.ptr[1:0])
                        flash_spm_pkg::SEL_FUSE_LOW: nxt_lpm_data =
                           fuses.fuse_low;
                        flash_spm_pkg::SEL_LOCK: nxt_lpm_data = fuses.lock;
                        flash_spm_pkg::SEL_FUSE_EXT: nxt_lpm_data =
                           fuses.fuse_ext;
                        default: nxt_lpm_data = fuses.fuse_high;
                     endcase
                  end
                  nxt_cmd = '0;
                  nxt_state = flash_spm_pkg::ST_IDLE;
               end else if (win_cnt >= (rd_cmd ? LPM_LAST : SPM_LAST)) begin
                  // a store during a read window lands here too
                  nxt_cmd = '0;
                  nxt_state = flash_spm_pkg::ST_IDLE;
               end
            end
         end
         flash_spm_pkg::ST_ERASE: begin
            if (flash_done) begin
               nxt_cmd = '0;
               nxt_state = flash_spm_pkg::ST_IDLE;
            end
         end
         flash_spm_pkg::ST_WRITE: begin
            if (flash_done) begin
               nxt_cmd = '0;
               nxt_loaded = '0;
               nxt_state = flash_spm_pkg::ST_IDLE;
            end
         end
         default: nxt_state = flash_spm_pkg::ST_IDLE;
      endcase
      if (eeprom_write) begin
         nxt_loaded = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff <= flash_spm_pkg::ST_IDLE;
         cmd_ff <= flash_spm_pkg::ctrl_t'(flash_spm_pkg::CTRL_RESET[5:0]);
         loaded_ff <= '0;
         page_ff <= '0;
         erase_req_ff <= 1'b0;
         write_req_ff <= 1'b0;
         lpm_valid_ff <= 1'b0;
         lpm_data_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cmd_ff <= nxt_cmd;
         loaded_ff <= nxt_loaded;
         page_ff <= nxt_page;
         erase_req_ff <= nxt_erase_req;
         write_req_ff <= nxt_write_req;
         lpm_valid_ff <= nxt_lpm_valid;
         lpm_data_ff <= nxt_lpm_data;
         rd_valid_ff <= loaded_ff[flash_rd_addr];
      end
   end

   window_timer #(.W(CW)) u_win (
      .clk_sys(clk_sys),
      .rst(rst),
      .restart(restart),
      .count(win_cnt)
   );

   page_buffer #(.AW(PW), .DW(16)) u_buf (
      .clk_sys(clk_sys),
      .wr_en(buf_we),
      .wr_addr(word_idx),
      .wr_data(req.data),
      .rd_addr(flash_rd_addr),
      .rd_data(buf_q)
   );

   // halt is a decode of the state so it drops with completion
   assign cpu_halt = state_ff[1];
   assign flash_erase_req = erase_req_ff;
   assign flash_write_req = write_req_ff;
   assign flash_page = page_ff;
   assign lpm_valid = lpm_valid_ff;
   assign lpm_data = lpm_data_ff;
   assign flash_rd_data = rd_valid_ff ? buf_q : flash_spm_pkg::ERASED_WORD;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic armed_ok;
   assign armed_ok = state_ff == flash_spm_pkg::ST_ARMED && !ctrl_wr;

   sequence s_erase_go;
      armed_ok && cmd_ff.page_erase_cmd && req.spm && win_cnt <= SPM_LAST;
   endsequence
   sequence s_arm_store;
      ctrl_wr && wr_legal && !wr_cmd[5] && !wr_cmd[3] && !cpu_halt;
   endsequence

   property p_erase_start;
      s_erase_go |=> flash_erase_req && cpu_halt &&
         flash_page == $past(page_idx);
   endproperty
   a_erase_start: assert property (p_erase_start)
      else $error("erase not started on store");
   property p_halt_hold;
      cpu_halt && !flash_done |=> cpu_halt && cmd_ff.en;
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("halt or enable dropped early");
   property p_release;
      cpu_halt && flash_done |=> !cpu_halt && cmd_ff == '0;
   endproperty
   a_release: assert property (p_release)
      else $error("no release on completion");
   property p_load;
      armed_ok && cmd_ff == flash_spm_pkg::ctrl_t'(flash_spm_pkg::CMD_LOAD)
      && req.spm && !eeprom_write && win_cnt <= SPM_LAST
      |=> loaded_ff[$past(word_idx)];
   endproperty
   a_load: assert property (p_load)
      else $error("word not loaded");
   property p_clear_write;
      state_ff == flash_spm_pkg::ST_WRITE && flash_done |=> loaded_ff == '0;
   endproperty
   a_clear_write: assert property (p_clear_write)
      else $error("buffer kept after write");
   property p_eeprom;
      eeprom_write |=> loaded_ff == '0;
   endproperty
   a_eeprom: assert property (p_eeprom)
      else $error("buffer kept after eeprom write");
   property p_expire;
      s_arm_store ##1 (!req.spm && !ctrl_wr)[*4] |=> cmd_ff == '0;
   endproperty
   a_expire: assert property (p_expire)
      else $error("window did not expire");
   property p_spm_ignored;
      armed_ok && rd_cmd && req.spm && !req.load_program_instruction && !eeprom_write
      |=> !cpu_halt && $stable(loaded_ff) && !lpm_valid;
   endproperty
   a_spm_ignored: assert property (p_spm_ignored)
      else $error("store acted during read window");
   property p_lock_read;
      armed_ok && cmd_ff.fuse_lock_read_cmd && req.load_program_instruction && win_cnt <= LPM_LAST &&
      req.ptr[1:0] == flash_spm_pkg::SEL_LOCK
      |=> lpm_valid && lpm_data == $past(fuses.lock);
   endproperty
   a_lock_read: assert property (p_lock_read)
      else $error("lock byte not returned");
   property p_illegal;
      ctrl_wr && !wr_legal && state_ff == flash_spm_pkg::ST_IDLE
      |=> state_ff == flash_spm_pkg::ST_IDLE && cmd_ff == '0;
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("illegal pattern took effect");
   property p_reserved;
      rvalid |-> rdata[7:flash_spm_pkg::CTRL_RSVD_LSB] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits not zero");
endmodule : flash_self_program_control

/* File: cpu_core_model.sv */
// Purpose: cpu core and flash macro stand-in for the bench
// Assumes: bench pulses go_spm or go_lpm for one cycle
// Notes: flash busy time set by dly; idle buses show inverted values
`timescale 1ns/1ps
module cpu_core_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic go_spm,
   input wire logic go_lpm,
   input wire logic [15:0] ptr,
   input wire logic [15:0] dat,
   input wire logic [7:0] dly,
   input wire logic cpu_halt,
   input wire logic op_req,
   output flash_spm_pkg::cpu_req_t req = '0,
   output logic flash_done = 1'h0
);
   // ----------------------------------------
   // instruction issue and flash busy count
   // ----------------------------------------
   logic [7:0] busy_ff = 8'h00;
   always @(posedge clk_sys) begin
      // a halted core fetches nothing, so it cannot issue
      req.spm <= go_spm && !cpu_halt && !rst;
      req.load_program_instruction <= go_lpm && !cpu_halt && !rst;
      // pointer and data pair mean nothing between instructions
      req.ptr <= (go_spm || go_lpm) ? ptr : ~req.ptr;
      req.data <= (go_spm || go_lpm) ? dat : ~req.data;
      busy_ff <= rst ? 8'h00 : op_req ? dly : busy_ff - (busy_ff != 8'h00);
      flash_done <= busy_ff == 8'h01;
   end
endmodule : cpu_core_model

/* File: test_flash_self_program_control.sv */
// Purpose: self-checking bench of the self-program controller
// Assumes: PW 6, flash busy time from the core model
// Notes: buffer model is an int array, 'hffff marks an empty word
`timescale 1ns/1ps
module test_flash_self_program_control;
   // ----------------------------------------
   // signals and model state
   // ----------------------------------------
   localparam logic [47:0] SIG = 48'h1f_2e_3d_4c_5b_6a; // arbitrary
   logic clk_sys = 1'h0, rst = 1'h1, go_spm = 1'h0, go_lpm = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, eeprom_write = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready;
   logic rvalid, cpu_halt, lpm_valid, flash_erase_req, flash_write_req;
   logic flash_done, c_lv, c_er, c_wr, c_h;
   logic [7:0] c_ld;
   logic [8:0] c_pg;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, lpm_data;
   logic [31:0] wdata = 32'h0, rdata, rd, r, seed = 32'h8813347b;
   logic [1:0] bresp, rresp, rs;
   logic [8:0] flash_page, pg;
   logic [5:0] flash_rd_addr = 6'h00;
   logic [15:0] flash_rd_data, ptr = 16'h0, dat = 16'h0;
   flash_spm_pkg::cpu_req_t req;
   flash_spm_pkg::fuse_set_t fuses = '0;
   int bufm [64];
   int miscompares = 0, n_compared = 0;
   always #20 clk_sys = ~clk_sys;
   flash_self_program_control #(.PW(6), .SIG_ROW(SIG))
   u_flash_self_program_control (
      .clk_sys(clk_sys), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .req(req),
      .eeprom_write(eeprom_write), .fuses(fuses), .cpu_halt(cpu_halt),
      .lpm_valid(lpm_valid), .lpm_data(lpm_data),
      .flash_erase_req(flash_erase_req), .flash_write_req(flash_write_req),
      .flash_page(flash_page), .flash_done(flash_done),
      .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data));
   cpu_core_model u_cpu_core_model (
      .clk_sys(clk_sys), .rst(rst), .go_spm(go_spm), .go_lpm(go_lpm),
      .ptr(ptr), .dat(dat), .dly(8'h1e), .cpu_halt(cpu_halt),
      .op_req(flash_erase_req | flash_write_req), .req(req),
      .flash_done(flash_done));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tmo(input int n);
      if (n >= 60) begin
         miscompares++;
         $display("MISMATCH %0t wait ran out", $time);
         tally_and_finish();
      end
   endtask : tmo
   task automatic axw(input logic [7:0] a, input logic [7:0] d);
      int n;
      logic at, wt, bt;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      // handshakes are judged on values settled before the edge
      do begin
         @(negedge clk_sys);
         at = awvalid && awready;
         wt = wvalid && wready;
         bt = bvalid;
         rs = bresp;
         @(posedge clk_sys);
         n++;
         if (at) awvalid <= 1'h0;
         if (wt) wvalid <= 1'h0;
      end while (!bt && n < 60);
      bready <= 1'h0;
      tmo(n);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      int n;
      logic at, bt;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge clk_sys);
         at = arvalid && arready;
         bt = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge clk_sys);
         n++;
         if (at) arvalid <= 1'h0;
      end while (!bt && n < 60);
      rready <= 1'h0;
      tmo(n);
   endtask : axr
   task automatic op(input logic l, input logic [15:0] p, input logic [15:0] d);
      ptr <= p;
      dat <= d;
      go_lpm <= l;
      go_spm <= !l;
      @(posedge clk_sys);
      go_lpm <= 1'h0;
      go_spm <= 1'h0;
      @(posedge clk_sys);
      // one-cycle answer pulses are caught while they stand
      @(negedge clk_sys);
      c_lv = lpm_valid;
      c_ld = lpm_data;
      c_er = flash_erase_req;
      c_wr = flash_write_req;
      c_h = cpu_halt;
      c_pg = flash_page;
      @(posedge clk_sys);
   endtask : op
   task automatic ld(input int w);
      r = xs();
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_LOAD});
      op(1'h0, {r[8:0], w[5:0], r[9]}, r[31:16]);
      bufm[w] = r[31:16];
   endtask : ld
   task automatic rdbuf(input int a);
      flash_rd_addr <= a[5:0];
      repeat (2) @(posedge clk_sys);
      chk(flash_rd_data, bufm[a]);
   endtask : rdbuf
   task automatic allbuf();
      for (int a = 0; a < 64; a++) rdbuf(a);
   endtask : allbuf
   task automatic wdone();
      int n;
      n = 0;
      while (cpu_halt && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      tmo(n);
      axr(8'h00);
      chk(rd, 0);
   endtask : wdone
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      foreach (bufm[i]) bufm[i] = 'hffff;
      fuses <= xs();
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      axr(flash_spm_pkg::CTRL_OFFS);
      chk(rd, flash_spm_pkg::CTRL_RESET);
      axr(8'h04);
      chk(rs, flash_spm_pkg::RESP_SLVERR);
      axw(8'h08, 8'h01);
      chk(rs, flash_spm_pkg::RESP_SLVERR);
      axw(8'h00, 8'h07);
      axr(8'h00);
      chk(rd, 0);
      axw(8'h00, 8'hc1);
      axr(8'h00);
      chk(rd[7:6], 0);
      repeat (6) @(posedge clk_sys);
      for (int s = 0; s < 4; s++) begin
         axw(8'h00, {2'h0, flash_spm_pkg::CMD_FUSE});
         op(1'h1, 16'(s), 16'h0);
         chk({c_lv, c_ld}, {1'h1, fuses[31-8*s -: 8]});
      end
      for (int k = 0; k < 7; k++) begin
         axw(8'h00, {2'h0, flash_spm_pkg::CMD_SIG});
         op(1'h1, 16'(k), 16'h0);
         chk({c_lv, c_ld}, {1'h1, k < 6 ? SIG[8*k +: 8] : 8'hff});
      end
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_SIG});
      op(1'h0, 16'h0006, 16'h1234);
      chk({c_er, c_h}, 0);
      repeat (4) @(posedge clk_sys);
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_LOAD});
      repeat (5) @(posedge clk_sys);
      op(1'h0, 16'h0012, 16'h5678);
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_ERASE});
      repeat (5) @(posedge clk_sys);
      axr(8'h00);
      chk(rd, 0);
      allbuf();
      for (int i = 0; i < 8; i++) ld((i * 37 + 5) % 64);
      r = xs();
      pg = r[24:16];
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_ERASE});
      op(1'h0, {pg, r[6:0]}, r[31:16]);
      chk({c_er, c_h, c_pg}, {2'h3, pg});
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_CLEAR});
      axr(8'h00);
      chk(rd, {2'h0, flash_spm_pkg::CMD_ERASE});
      wdone();
      for (int i = 8; i < 16; i++) ld((i * 37 + 5) % 64);
      allbuf();
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_WRITE});
      op(1'h0, {pg, 7'h00}, 16'(xs()));
      chk({c_wr, c_h, c_pg}, {2'h3, pg});
      wdone();
      foreach (bufm[i]) bufm[i] = 'hffff;
      allbuf();
      ld(3);
      axw(8'h00, {2'h0, flash_spm_pkg::CMD_CLEAR});
      bufm[3] = 'hffff;
      rdbuf(3);
      ld(4);
      eeprom_write <= 1'h1;
      @(posedge clk_sys);
      eeprom_write <= 1'h0;
      bufm[4] = 'hffff;
      rdbuf(4);
      ld(5);
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      bufm[5] = 'hffff;
      rdbuf(5);
      tally_and_finish();
   end
endmodule : test_flash_self_program_control
